// ---- design/emi_cfg.svh ----
// constants for the external data memory interface: register indices, field positions,
// reset values and fixed cycle counts.
// assumes inclusion by bare name from the package and the top module.
`ifndef EMI_CFG_SVH
`define EMI_CFG_SVH

// printed register indices; byte address on the bus is four times the index
`define EMI_IDX_TIMING 12'h0a1
`define EMI_IDX_CONFIG 12'h0a3
`define EMI_IDX_PAGE 12'h0af
`define EMI_IDX_STATUS 12'h0c0

`define EMI_RST_TIMING 8'hff
`define EMI_RST_CONFIG 8'h03
`define EMI_RST_PAGE 8'h00

// bus_timing_reg fields
`define EMI_SETUP_MSB 7
`define EMI_SETUP_LSB 6
`define EMI_STROBE_MSB 5
`define EMI_STROBE_LSB 2
`define EMI_HOLD_MSB 1
`define EMI_HOLD_LSB 0

// memory_config_reg fields
`define EMI_MUX_BIT 4
`define EMI_MODE_MSB 3
`define EMI_MODE_LSB 2
`define EMI_LATCH_MSB 1
`define EMI_LATCH_LSB 0
`define EMI_CONFIG_MASK 8'h1f

// status register bits
`define EMI_STAT_BUSY 0
`define EMI_STAT_OFFCHIP 1
`define EMI_STAT_WRITE 2

// fixed cycles of an off-chip access: one lead cycle, three tail cycles
`define EMI_FRONT_CYCLES 5'h01
`define EMI_TAIL_CYCLES 5'h03

// on-chip / off-chip split boundary (4k)
`define EMI_SPLIT_BOUNDARY 16'h1000

`define EMI_RESP_OKAY 2'h0
`define EMI_RESP_SLVERR 2'h2

`endif

// ---- design/emi_pkg.sv ----
// types for the external data memory interface.
// assumes emi_cfg.svh on the include path.
`include "emi_cfg.svh"
`default_nettype none

package emi_pkg;

   typedef enum logic [3:0] {
      st_idle,
      st_onchip,
      st_front,
      st_ale_high,
      st_ale_low,
      st_setup,
      st_strobe,
      st_hold,
      st_tail
   } emi_state_type;

   typedef enum logic [2:0] {
      sel_timing,
      sel_config,
      sel_page,
      sel_status,
      sel_none
   } emi_regsel_type;

   typedef struct packed {
      // register file
      logic [7:0] bus_timing_reg;
      logic [7:0] memory_config_reg;
      logic [7:0] page_select_reg;
      // register bus slave
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [11:0] aw_idx;
      logic [7:0] w_byte;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      // access sequencer
      emi_state_type st;
      logic [4:0] cnt;
      logic mux_mode;
      logic [1:0] latch_code;
      logic [15:0] acc_addr;
      logic acc_write;
      logic acc_drive_hi;
      logic [7:0] acc_wdata;
      logic last_offchip;
      // core side
      logic req_ready;
      logic resp_valid;
      logic [7:0] resp_rdata;
      logic resp_offchip;
      // pins
      logic bus_owned;
      logic [7:0] addr_hi_o;
      logic addr_hi_oe;
      logic [7:0] addr_lo_o;
      logic addr_lo_oe;
      logic [7:0] data_o;
      logic data_oe;
      logic ale;
      logic rd_n;
      logic wr_n;
   } emi_regs_type;

endpackage : emi_pkg

`default_nettype wire

// ---- design/emi_top.sv ----
// external data memory interface: register bus slave, map decode, on-chip ram and
// the off-chip bus sequencer for shared and separate address/data pins.
// assumes a core issuing one external move at a time on the req port and port
// logic that resolves pin levels from the _oe outputs.
//
// Our own choice: the AXI4-Lite register port.
`include "emi_cfg.svh"
`default_nettype none

// What this block does
// - off-chip bus runs shared address/data or separate pins per mux select bit.
// - shared mode puts data and low address byte on the same eight pins.
// - shared mode drives low address byte first while latch strobe is high.
// - after latch strobe falls, data is driven or sampled under read/write strobe.
// - separate-pins mode keeps address and data on distinct pins.
// - mode 00 sends every access on-chip, addresses wrap modulo 4k.
// - internal-only 8-bit access address is page select high, indirect pointer low.
// - internal-only 16-bit access address is the data pointer.
// - mode 01 sends addresses below 4k on-chip, others off-chip.
// - mode 01 8-bit off-chip access drives low byte only, upper pins undriven.
// - split modes decide 16-bit accesses by data pointer, drive all sixteen lines.
// - mode 10 splits the map at 4k like mode 01.
// - mode 10 8-bit off-chip access drives page high byte and pointer low byte.
// - mode 11 sends every access off-chip, on-chip ram hidden.
// - mode 11 8-bit access ignores page, upper lines undriven, pointer low byte.
// - mode 11 16-bit access drives all sixteen lines from the data pointer.
// - setup field, bits 7-6, gives zero to three cycles.
// - strobe field, bits 5-2, code n gives n+1 cycles.
// - hold field, bits 1-0, gives zero to three cycles.
// - off-chip access is programmed timing plus four cycles, minimum five.
// - shared mode adds latch strobe cycles, at least two, minimum seven.
// - timing register resets to all ones.
// - pins are owned only during an off-chip access, then released.
// - drivers of pins acting as inputs are off during the access.
module emi_top #(
   parameter int RAM_AW = 12 // on-chip ram address width (4k)
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   // axi4-lite slave
   input wire logic [31:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [31:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   // core external move requests
   input wire logic req_valid, // external_move_instruction issued
   output logic req_ready, // sequencer idle, request taken
   input wire logic req_write, // 1 write, 0 read
   input wire logic req_wide, // 1 uses data_pointer, 0 uses indirect pointer
   input wire logic [7:0] indirect_pointer_reg, // 8-bit pointer value
   input wire logic [15:0] data_pointer, // 16-bit pointer value
   input wire logic [7:0] req_wdata, // write byte
   output logic resp_valid, // one-cycle completion pulse
   output logic [7:0] resp_rdata, // read byte
   output logic resp_offchip, // completed access went off-chip
   // port pins
   output logic bus_owned, // interface holds the port pins
   output logic [7:0] addr_hi_o, // address bits 15:8
   output logic addr_hi_oe, // drive address bits 15:8
   output logic [7:0] addr_lo_o, // address bits 7:0, separate-pins mode
   output logic addr_lo_oe, // drive address bits 7:0
   output logic [7:0] data_o, // data or shared address/data out
   output logic data_oe, // drive data pins
   input wire logic [7:0] data_i, // data pins in
   output logic ale, // address latch strobe, active high
   output logic rd_n, // read strobe, active low
   output logic wr_n // write strobe, active low
);

   emi_pkg::emi_regs_type s;
   emi_pkg::emi_regs_type n;
   logic [7:0] ram [0:(1 << RAM_AW) - 1];

   function automatic emi_pkg::emi_regsel_type reg_decode(input logic [31:0] addr);
      emi_pkg::emi_regsel_type sel;
      sel = emi_pkg::sel_none;
      if (addr[1:0] == 2'h0 && addr[31:14] == 18'h0_0000)
      begin
         unique case (addr[13:2])
            `EMI_IDX_TIMING: sel = emi_pkg::sel_timing;
            `EMI_IDX_CONFIG: sel = emi_pkg::sel_config;
            `EMI_IDX_PAGE: sel = emi_pkg::sel_page;
            `EMI_IDX_STATUS: sel = emi_pkg::sel_status;
            default: sel = emi_pkg::sel_none;
         endcase
      end
      return sel;
   endfunction : reg_decode

   always_comb
   begin
      logic [15:0] ea;
      logic offchip;
      logic drive_hi;
      logic [1:0] mode;
      logic [4:0] strobe_len;
      logic [4:0] latch_len;
      ea = 16'h0000;
      offchip = 1'b0;
      drive_hi = 1'b0;
      mode = s.memory_config_reg[`EMI_MODE_MSB:`EMI_MODE_LSB];
      strobe_len = 5'(s.bus_timing_reg[`EMI_STROBE_MSB:`EMI_STROBE_LSB]) + 5'h01;
      latch_len = 5'(s.latch_code) + 5'h01;
      n = s;
      n.resp_valid = 1'b0;

      // register bus: write path; address and data taken in either order
      if (s_axi_awvalid && s.awready)
      begin
         n.awready = 1'b0;
         n.aw_got = 1'b1;
         n.aw_idx = s_axi_awaddr[13:2];
      end
      if (s_axi_wvalid && s.wready)
      begin
         n.wready = 1'b0;
         n.w_got = 1'b1;
         n.w_byte = s_axi_wdata[7:0];
         n.w_lane0 = s_axi_wstrb[0];
      end
      if (s.aw_got && s.w_got && !s.bvalid)
      begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `EMI_RESP_OKAY;
         unique case (reg_decode({18'h0_0000, s.aw_idx, 2'h0}))
            emi_pkg::sel_timing:
               if (s.w_lane0) n.bus_timing_reg = s.w_byte;
            emi_pkg::sel_config:
               if (s.w_lane0) n.memory_config_reg = s.w_byte & `EMI_CONFIG_MASK;
            emi_pkg::sel_page:
               if (s.w_lane0) n.page_select_reg = s.w_byte;
            emi_pkg::sel_status: n.bresp = `EMI_RESP_OKAY;
            emi_pkg::sel_none: n.bresp = `EMI_RESP_SLVERR;
         endcase
      end
      if (s.bvalid && s_axi_bready)
      begin
         n.bvalid = 1'b0;
         n.awready = 1'b1;
         n.wready = 1'b1;
      end

      // register bus: read path, answer one cycle after the address is taken
      if (s_axi_arvalid && s.arready)
      begin
         n.arready = 1'b0;
         n.rvalid = 1'b1;
         n.rresp = `EMI_RESP_OKAY;
         n.rdata = 32'h0000_0000;
         unique case (reg_decode(s_axi_araddr))
            emi_pkg::sel_timing: n.rdata[7:0] = s.bus_timing_reg;
            emi_pkg::sel_config: n.rdata[7:0] = s.memory_config_reg;
            emi_pkg::sel_page: n.rdata[7:0] = s.page_select_reg;
            emi_pkg::sel_status:
            begin
               n.rdata[`EMI_STAT_BUSY] = (s.st != emi_pkg::st_idle);
               n.rdata[`EMI_STAT_OFFCHIP] = s.last_offchip;
               n.rdata[`EMI_STAT_WRITE] = s.acc_write;
            end
            emi_pkg::sel_none: n.rresp = `EMI_RESP_SLVERR;
         endcase
      end
      if (s.rvalid && s_axi_rready)
      begin
         n.rvalid = 1'b0;
         n.arready = 1'b1;
      end

      // map decode of the requested access
      ea = req_wide ? data_pointer : {s.page_select_reg, indirect_pointer_reg};
      unique case (mode)
         2'b00: offchip = 1'b0;
         2'b01, 2'b10: offchip = (ea >= `EMI_SPLIT_BOUNDARY);
         2'b11: offchip = 1'b1;
      endcase
      // 8-bit off-chip accesses drive the upper byte only with bank select
      drive_hi = req_wide || (mode == 2'b10);

      // access sequencer
      unique case (s.st)
         emi_pkg::st_idle:
            if (req_valid && s.req_ready)
            begin
               n.req_ready = 1'b0;
               n.acc_addr = ea;
               n.acc_write = req_write;
               n.acc_wdata = req_wdata;
               n.acc_drive_hi = drive_hi;
               n.last_offchip = offchip;
               // mode and latch width frozen for the whole access
               n.mux_mode = !s.memory_config_reg[`EMI_MUX_BIT];
               n.latch_code = s.memory_config_reg[`EMI_LATCH_MSB:`EMI_LATCH_LSB];
               if (offchip)
               begin
                  n.st = emi_pkg::st_front;
                  n.cnt = `EMI_FRONT_CYCLES;
               end
               else
               begin
                  n.st = emi_pkg::st_onchip;
               end
            end
         emi_pkg::st_onchip:
         begin
            // address wraps on the 4k boundary
            n.resp_rdata = ram[s.acc_addr[RAM_AW-1:0]];
            n.resp_offchip = 1'b0;
            n.resp_valid = 1'b1;
            n.req_ready = 1'b1;
            n.st = emi_pkg::st_idle;
         end
         emi_pkg::st_front:
            if (s.cnt == 5'h01)
            begin
               if (s.mux_mode)
               begin
                  n.st = emi_pkg::st_ale_high;
                  n.cnt = latch_len;
               end
               else
               begin
                  n.st = emi_pkg::st_setup;
                  n.cnt = 5'(s.bus_timing_reg[`EMI_SETUP_MSB:`EMI_SETUP_LSB]);
               end
            end
            else
            begin
               n.cnt = s.cnt - 5'h01;
            end
         emi_pkg::st_ale_high:
            if (s.cnt == 5'h01)
            begin
               n.st = emi_pkg::st_ale_low;
               n.cnt = latch_len;
            end
            else
            begin
               n.cnt = s.cnt - 5'h01;
            end
         emi_pkg::st_ale_low:
            if (s.cnt == 5'h01)
            begin
               n.st = emi_pkg::st_setup;
               n.cnt = 5'(s.bus_timing_reg[`EMI_SETUP_MSB:`EMI_SETUP_LSB]);
            end
            else
            begin
               n.cnt = s.cnt - 5'h01;
            end
         emi_pkg::st_setup:
            // a zero setup code falls straight through to the strobe
            if (s.cnt <= 5'h01)
            begin
               n.st = emi_pkg::st_strobe;
               n.cnt = strobe_len;
            end
            else
            begin
               n.cnt = s.cnt - 5'h01;
            end
         emi_pkg::st_strobe:
            if (s.cnt == 5'h01)
            begin
               // read data captured on the last strobe edge
               if (!s.acc_write) n.resp_rdata = data_i;
               n.st = emi_pkg::st_hold;
               n.cnt = 5'(s.bus_timing_reg[`EMI_HOLD_MSB:`EMI_HOLD_LSB]);
            end
            else
            begin
               n.cnt = s.cnt - 5'h01;
            end
         emi_pkg::st_hold:
            if (s.cnt <= 5'h01)
            begin
               n.st = emi_pkg::st_tail;
               n.cnt = `EMI_TAIL_CYCLES;
            end
            else
            begin
               n.cnt = s.cnt - 5'h01;
            end
         emi_pkg::st_tail:
            if (s.cnt == 5'h01)
            begin
               n.resp_valid = 1'b1;
               n.resp_offchip = 1'b1;
               n.req_ready = 1'b1;
               n.st = emi_pkg::st_idle;
            end
            else
            begin
               n.cnt = s.cnt - 5'h01;
            end
      endcase

      // zero setup/hold states are skipped at entry rather than spent
      if (n.st == emi_pkg::st_setup && n.cnt == 5'h00 && s.st != emi_pkg::st_setup)
      begin
         n.st = emi_pkg::st_strobe;
         n.cnt = strobe_len;
      end
      if (n.st == emi_pkg::st_hold && n.cnt == 5'h00 && s.st != emi_pkg::st_hold)
      begin
         n.st = emi_pkg::st_tail;
         n.cnt = `EMI_TAIL_CYCLES;
      end

      // pin outputs follow the next state so they change with it
      n.bus_owned = 1'b0;
      n.addr_hi_oe = 1'b0;
      n.addr_lo_oe = 1'b0;
      n.data_oe = 1'b0;
      n.ale = 1'b0;
      n.rd_n = 1'b1;
      n.wr_n = 1'b1;
      // last driven values are kept; only the enables release the pins
      if (n.st inside {emi_pkg::st_front, emi_pkg::st_ale_high, emi_pkg::st_ale_low,
                       emi_pkg::st_setup, emi_pkg::st_strobe, emi_pkg::st_hold})
      begin
         n.bus_owned = 1'b1;
         n.addr_hi_o = n.acc_addr[15:8];
         n.addr_hi_oe = n.acc_drive_hi;
         if (n.mux_mode)
         begin
            if (n.st inside {emi_pkg::st_front, emi_pkg::st_ale_high, emi_pkg::st_ale_low})
            begin
               // address byte held on the shared pins through the latch pulse
               n.data_o = n.acc_addr[7:0];
               n.data_oe = 1'b1;
               n.ale = (n.st == emi_pkg::st_ale_high);
            end
            else
            begin
               n.data_o = n.acc_wdata;
               n.data_oe = n.acc_write;
            end
         end
         else
         begin
            n.addr_lo_o = n.acc_addr[7:0];
            n.addr_lo_oe = 1'b1;
            n.data_o = n.acc_wdata;
            n.data_oe = n.acc_write;
         end
         if (n.st == emi_pkg::st_strobe)
         begin
            n.rd_n = n.acc_write;
            n.wr_n = !n.acc_write;
         end
      end
      else if (n.st == emi_pkg::st_tail)
      begin
         // pins released for the tail so the port latches take over
         n.bus_owned = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
         s.bus_timing_reg <= `EMI_RST_TIMING;
         s.memory_config_reg <= `EMI_RST_CONFIG;
         s.page_select_reg <= `EMI_RST_PAGE;
         s.awready <= 1'b1;
         s.wready <= 1'b1;
         s.arready <= 1'b1;
         s.req_ready <= 1'b1;
         s.st <= emi_pkg::st_idle;
         s.rd_n <= 1'b1;
         s.wr_n <= 1'b1;
      end
      else
      begin
         s <= n;
      end
   end

   // on-chip ram write; no reset, contents undefined after power-up
   always_ff @(posedge aclk)
   begin
      if (s.st == emi_pkg::st_onchip && s.acc_write)
      begin
         ram[s.acc_addr[RAM_AW-1:0]] <= s.acc_wdata;
      end
   end

   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bresp = s.bresp;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_arready = s.arready;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rvalid = s.rvalid;
   assign req_ready = s.req_ready;
   assign resp_valid = s.resp_valid;
   assign resp_rdata = s.resp_rdata;
   assign resp_offchip = s.resp_offchip;
   assign bus_owned = s.bus_owned;
   assign addr_hi_o = s.addr_hi_o;
   assign addr_hi_oe = s.addr_hi_oe;
   assign addr_lo_o = s.addr_lo_o;
   assign addr_lo_oe = s.addr_lo_oe;
   assign data_o = s.data_o;
   assign data_oe = s.data_oe;
   assign ale = s.ale;
   assign rd_n = s.rd_n;
   assign wr_n = s.wr_n;

endmodule : emi_top

`default_nettype wire

// ---- test/emi_top_sva.sv ----
// checker: pin sequencer and core handshake of emi_top.
// assumes binding to emi_top; sees its ports only.
`default_nettype none
module emi_top_sva (
   input wire logic aclk, // clock
   input wire logic aresetn, // reset
   input wire logic req_valid, // request
   input wire logic req_ready, // idle
   input wire logic resp_valid, // done
   input wire logic resp_offchip, // went off-chip
   input wire logic bus_owned, // pins held
   input wire logic addr_hi_oe, // a15:8 drive
   input wire logic addr_lo_oe, // a7:0 drive
   input wire logic data_oe, // data drive
   input wire logic ale, // latch strobe
   input wire logic rd_n, // read strobe
   input wire logic wr_n // write strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_take;
      req_valid && req_ready;
   endsequence
   sequence s_off_start;
      s_take ##1 bus_owned;
   endsequence
   a_ale_addr: assert property (ale |-> data_oe && bus_owned)
      else $error("latch strobe without address");
   a_strobe_phase: assert property (!rd_n || !wr_n |-> !ale)
      else $error("strobe inside latch phase");
   a_write_drive: assert property (!wr_n |-> data_oe && rd_n)
      else $error("write strobe without data");
   a_read_float: assert property (!rd_n |-> !data_oe && bus_owned)
      else $error("data driven during read");
   a_pins_free: assert property
      (!bus_owned |-> !(data_oe || addr_lo_oe || addr_hi_oe || ale) && rd_n && wr_n)
      else $error("pins held outside access");
   a_sep_no_ale: assert property (addr_lo_oe |-> !ale)
      else $error("latch strobe on separate pins");
   a_off_min: assert property (s_off_start |-> !resp_valid [*5])
      else $error("off-chip access too short");
   a_off_done: assert property (s_off_start |-> ##[5:34] (resp_valid && resp_offchip))
      else $error("off-chip access not finished");
   a_on_fast: assert property
      (s_take ##1 !bus_owned |-> ##1 (resp_valid && !resp_offchip))
      else $error("on-chip access late");
endmodule : emi_top_sva
bind emi_top emi_top_sva i_sva (.aclk(aclk), .aresetn(aresetn), .req_valid(req_valid),
   .req_ready(req_ready), .resp_valid(resp_valid), .resp_offchip(resp_offchip),
   .bus_owned(bus_owned), .addr_hi_oe(addr_hi_oe), .addr_lo_oe(addr_lo_oe),
   .data_oe(data_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
`default_nettype wire

// ---- test/emi_ext_mem.sv ----
// external byte memory with its address latch for the shared bus.
// assumes upper address pins park high while the interface leaves them undriven.
`default_nettype none
module emi_ext_mem (
   input wire logic aclk, // clock
   input wire logic sep_mode, // separate address/data pins
   input wire logic [7:0] addr_hi_o, // a15:8
   input wire logic addr_hi_oe, // a15:8 driven
   input wire logic [7:0] addr_lo_o, // a7:0, separate pins
   input wire logic [7:0] data_o, // data or shared address/data
   input wire logic ale, // latch strobe
   input wire logic rd_n, // read strobe
   input wire logic wr_n, // write strobe
   output logic [7:0] data_i // data to the interface
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [65536];
   logic [7:0] lat;
   logic [7:0] last = 8'h00;
   logic [15:0] addr;
   always_latch
      if (ale)
         lat = data_o;
   assign addr = {addr_hi_oe ? addr_hi_o : 8'hff, sep_mode ? addr_lo_o : lat};
   always @(posedge aclk)
   begin
      if (!wr_n)
         mem[addr] <= data_o;
      if (!rd_n)
         last <= mem[addr];
   end
   // a released bus shows the inverse of the last byte, so stale data never passes
   assign data_i = !rd_n ? mem[addr] : ~last;
endmodule : emi_ext_mem
`default_nettype wire

// ---- test/tb_top.sv ----
// bench for emi_top: register bus, map decode and off-chip access timing.
// assumes emi_ext_mem on the far side of the port pins.
`include "emi_cfg.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] adr_tc = {18'h0_0000, `EMI_IDX_TIMING, 2'h0};
   localparam logic [31:0] adr_cf = {18'h0_0000, `EMI_IDX_CONFIG, 2'h0};
   localparam logic [31:0] adr_pg = {18'h0_0000, `EMI_IDX_PAGE, 2'h0};
   // config, timing, access cycles worked out from the codes
   localparam logic [7:0] tim_tab [5][3] = '{'{8'h1c, 8'h00, 8'h05}, '{8'h0c, 8'h00, 8'h07},
      '{8'h0f, 8'hff, 8'h22}, '{8'h0e, 8'h55, 8'h12}, '{8'h1f, 8'hb4, 8'h14}};
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic req_valid = 1'h0, req_write = 1'h0, req_wide = 1'h0, sep_mode = 1'h0;
   logic req_ready, resp_valid, resp_offchip, bus_owned, addr_hi_oe, addr_lo_oe, data_oe;
   logic ale, rd_n, wr_n, got_off;
   logic [7:0] indirect_pointer_reg = 8'h00, req_wdata = 8'h00, resp_rdata, got_rd;
   logic [7:0] addr_hi_o, addr_lo_o, data_o, data_i;
   logic [15:0] data_pointer = 16'h0000;
   int errors = 0;
   int checks = 0;
   int cyc;
   emi_top i_dut (.*);
   emi_ext_mem i_mem (.*);
   always #2.5 aclk = ~aclk;
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic axi_wr(logic [31:0] a, logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
      end
      while (s_axi_bvalid !== 1'h1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : axi_wr
   task automatic axi_rd(logic [31:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'h0;
      end
      while (s_axi_rvalid !== 1'h1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : axi_rd
   task automatic setup(logic [7:0] c, logic [7:0] t, logic [7:0] pg);
      axi_wr(adr_cf, c);
      axi_wr(adr_tc, t);
      axi_wr(adr_pg, pg);
      sep_mode = c[4];
   endtask : setup
   task automatic core(logic w, logic wide, logic [7:0] p, logic [15:0] dp, logic [7:0] d);
      @(posedge aclk);
      req_valid <= 1'h1;
      req_write <= w;
      req_wide <= wide;
      indirect_pointer_reg <= p;
      data_pointer <= dp;
      req_wdata <= d;
      do
         @(posedge aclk);
      while (req_ready !== 1'h1);
      req_valid <= 1'h0;
      cyc = 0;
      do
      begin
         @(posedge aclk);
         cyc++;
      end
      while (resp_valid !== 1'h1);
      got_rd = resp_rdata;
      got_off = resp_offchip;
   endtask : core
   task automatic wr_chk(logic [7:0] c, logic [7:0] pg, logic wide, logic [7:0] p,
      logic [15:0] dp, logic [7:0] d, logic off, logic [15:0] ma);
      setup(c, 8'h00, pg);
      core(1'h1, wide, p, dp, d);
      chk("offchip", {31'h0000_0000, off}, {31'h0000_0000, got_off});
      if (off)
         chk("ext byte", d, i_mem.mem[ma]);
      else
         chk("onchip cycles", 32'h0000_0002, cyc);
   endtask : wr_chk
   task automatic t_regs();
      axi_rd(adr_tc);
      chk("timing reset", 32'h0000_00ff, rd);
      axi_rd(adr_cf);
      chk("config reset", 32'h0000_0003, rd);
      axi_wr(adr_tc, 8'h55);
      axi_wr(32'h0000_0400, 8'h00);
      chk("unmapped resp", `EMI_RESP_SLVERR, rs);
      axi_rd(adr_tc);
      chk("timing write", 32'h0000_0055, rd);
   endtask : t_regs
   task automatic t_timing();
      for (int i = 0; i < 5; i++)
      begin
         setup(tim_tab[i][0], tim_tab[i][1], 8'h00);
         core(1'h1, 1'h1, 8'h00, 16'h0100 + 16'(i), 8'ha0 + 8'(i));
         chk("write cycles", 32'(tim_tab[i][2]) + 1, cyc);
         chk("ext byte", 8'ha0 + 8'(i), i_mem.mem[16'h0100 + 16'(i)]);
         core(1'h0, 1'h1, 8'h00, 16'h0100 + 16'(i), 8'h00);
         chk("read data", 8'ha0 + 8'(i), got_rd);
         chk("read cycles", 32'(tim_tab[i][2]) + 1, cyc);
      end
      axi_rd({18'h0_0000, `EMI_IDX_STATUS, 2'h0});
      chk("status", 32'h0000_0002, rd);
   endtask : t_timing
   task automatic t_map();
      wr_chk(8'h14, 8'h20, 1'h0, 8'h44, 16'h0000, 8'h11, 1'h1, 16'hff44);
      wr_chk(8'h18, 8'h21, 1'h0, 8'h45, 16'h0000, 8'h22, 1'h1, 16'h2145);
      wr_chk(8'h08, 8'h22, 1'h0, 8'h47, 16'h0000, 8'h23, 1'h1, 16'h2247);
      wr_chk(8'h1c, 8'h33, 1'h0, 8'h46, 16'h0000, 8'h33, 1'h1, 16'hff46);
      wr_chk(8'h14, 8'h00, 1'h1, 8'h00, 16'h0800, 8'h44, 1'h0, 16'h0000);
      wr_chk(8'h18, 8'h00, 1'h1, 8'h00, 16'h3000, 8'h55, 1'h1, 16'h3000);
      wr_chk(8'h10, 8'h05, 1'h0, 8'h66, 16'h0000, 8'h66, 1'h0, 16'h0000);
      core(1'h0, 1'h1, 8'h00, 16'h1566, 8'h00);
      chk("wrap read", 8'h66, got_rd);
      core(1'h0, 1'h1, 8'h00, 16'h0800, 8'h00);
      chk("onchip read", 8'h44, got_rd);
   endtask : t_map
   task automatic finish_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test
   // the whole run needs well under 10 us
   initial
   begin
      #50us;
      errors++;
      finish_test();
   end
   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs();
      t_timing();
      t_map();
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
